// ===== verilog/era_pkg.sv
// Shared constants and types for the expander reset, debounce and alert block
package era_pkg;
    localparam int NUM_LINES = 18;
    localparam int NUM_PORTS = 3;
    localparam int PORT_WIDTH = 8;
    localparam int CLK_PERIOD_NS = 10;
    // Debounce clock period, in ns
    localparam int DEB_PERIOD_NS = 50000;
    localparam int DEB_CYCLES = DEB_PERIOD_NS / CLK_PERIOD_NS;
    // Alert clear bound, in ns
    localparam int ALERT_CLEAR_MAX_NS = 1000;
    localparam int ALERT_CLEAR_CYCLES = ALERT_CLEAR_MAX_NS / CLK_PERIOD_NS;
    localparam logic [NUM_LINES-1:0] DIR_RESET = 18'h00000;
    localparam logic [NUM_LINES-1:0] PULL_RESET = 18'h3FFFF;
    localparam logic [NUM_LINES-1:0] DATA_RESET = 18'h00000;
    localparam logic DEB_OFF_RESET = 1'b0;

    typedef struct packed {
        logic [NUM_LINES-1:0] dir;
        logic [NUM_LINES-1:0] pull_en;
        logic [NUM_LINES-1:0] data;
        logic deb_off;
    } era_cfg_t;

    localparam era_cfg_t CFG_RESET = '{
        dir: DIR_RESET,
        pull_en: PULL_RESET,
        data: DATA_RESET,
        deb_off: DEB_OFF_RESET
    };
endpackage

// ===== verilog/era_debounce.sv
// Two-stage debounce register bank clocked by a shared tick
`timescale 1ns/1ps
module era_debounce (
    input wire logic clk_i,                          // System clock
    input wire logic rst_i,                          // Async reset
    input wire logic clr_i,                          // Sync clear
    input wire logic tick_i,                         // Debounce clock edge
    input wire logic [era_pkg::NUM_LINES-1:0] in_i,  // Raw inputs
    output logic [era_pkg::NUM_LINES-1:0] out_o      // Debounced level
);
    logic [era_pkg::NUM_LINES-1:0] stage1;
    logic [era_pkg::NUM_LINES-1:0] stage2;
    logic [era_pkg::NUM_LINES-1:0] next_stage1;
    logic [era_pkg::NUM_LINES-1:0] next_stage2;

    always_comb begin
        next_stage1 = stage1;
        next_stage2 = stage2;
        if (clr_i) begin
            next_stage1 = era_pkg::DATA_RESET;
            next_stage2 = era_pkg::DATA_RESET;
        end else if (tick_i) begin
            next_stage1 = in_i;
            next_stage2 = (in_i & stage1 & stage2) | (in_i & stage1 & ~stage2)
                | (stage2 & (in_i ^ stage1));
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stage1 <= era_pkg::DATA_RESET;
            stage2 <= era_pkg::DATA_RESET;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
        end
    end

    assign out_o = stage2;

    AST_STAGE2_CONFIRM: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (tick_i && !clr_i) |=>
            (stage2 == (($past(in_i) & $past(stage1))
                | ($past(stage2) & ($past(in_i) ^ $past(stage1))))))
        else $error("second stage took an unconfirmed level");
    AST_STAGE_HOLD: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!tick_i && !clr_i) |=> ($stable(stage1) && $stable(stage2)))
        else $error("debounce stage moved without a tick");
endmodule

// ===== verilog/era_top.sv
// Reset handling, input debounce and input-change alert of the expander
//
// Functional notes
// - Inputs pass two stages on shared tick
// - Second stage loads only confirmed level
// - Debounce latency up to two ticks
// - Reset pin low forces all defaults except the free-running tick counter
// - Port levels change only out of reset
// - Lines default to input with pulldown
// - Power-on reset matches reset pin; it also zeroes the tick counter, which the pin leaves running
// - Open-drain alert reports input change
// - Alert valid within debounce bounds
// - Read acknowledge drops alert within 1us
// - Alert clears on revert or port read
// - Outputs and foreign traffic never alert
`timescale 1ns/1ps
module era_top #(
    parameter int DEB_CYCLES = era_pkg::DEB_CYCLES
) (
    input wire logic clk_i,                             // System clock
    input wire logic rst_i,                             // Power-on reset
    input wire logic reset_n_i,                         // Reset pin, low
    input wire logic [era_pkg::NUM_LINES-1:0] gpio_i,   // Pin levels
    input wire logic cfg_wr_i,                          // Config strobe
    input wire era_pkg::era_cfg_t cfg_i,                // Config value
    input wire logic [era_pkg::NUM_PORTS-1:0] rd_ack_i, // Port read ack
    output era_pkg::era_cfg_t cfg_o,                    // Active config
    output logic [era_pkg::NUM_LINES-1:0] gpio_o,       // Pin drive level
    output logic [era_pkg::NUM_LINES-1:0] gpio_oe_o,    // Pin drive enable
    output logic [era_pkg::NUM_LINES-1:0] in_level_o,   // Filtered inputs
    output logic input_change_flag_o,                   // Pending change
    output logic alert_o,                               // Alert pin level
    output logic alert_oe_o                             // Alert pulls low
);
    localparam int TW = $clog2(DEB_CYCLES);

    function automatic logic [era_pkg::NUM_LINES-1:0] port_mask(
        input logic [era_pkg::NUM_PORTS-1:0] ack
    );
        logic [era_pkg::NUM_LINES-1:0] m;
        m = '0;
        for (int p = 0; p < era_pkg::NUM_PORTS; p++) begin
            for (int b = 0; b < era_pkg::PORT_WIDTH; b++) begin
                if (p * era_pkg::PORT_WIDTH + b < era_pkg::NUM_LINES) begin
                    m[p * era_pkg::PORT_WIDTH + b] = ack[p];
                end
            end
        end
        return m;
    endfunction

    // reset pin acts as a synchronous clear
    logic clr;
    assign clr = !reset_n_i;

    // Free-running debounce tick
    logic [TW-1:0] tick_cnt;
    logic [TW-1:0] next_tick_cnt;
    logic tick;

    always_comb begin
        if (tick_cnt == TW'(DEB_CYCLES - 1)) begin
            next_tick_cnt = '0;
        end else begin
            next_tick_cnt = tick_cnt + TW'(1);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= next_tick_cnt;
        end
    end

    assign tick = (tick_cnt == TW'(DEB_CYCLES - 1));

    // Configuration
    era_pkg::era_cfg_t cfg;
    era_pkg::era_cfg_t next_cfg;

    always_comb begin
        next_cfg = cfg;
        if (clr) begin
            next_cfg = era_pkg::CFG_RESET;
        end else if (cfg_wr_i) begin
            // changes accepted only out of reset
            next_cfg = cfg_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg <= era_pkg::CFG_RESET;
        end else begin
            cfg <= next_cfg;
        end
    end

    // Debounce path
    logic [era_pkg::NUM_LINES-1:0] deb_level;

    // latency is one to two tick periods
    era_debounce u_deb (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(clr),
        .tick_i(tick),
        .in_i(gpio_i),
        .out_o(deb_level)
    );

    // Alert state
    logic [era_pkg::NUM_LINES-1:0] level;
    logic [era_pkg::NUM_LINES-1:0] ref_level;
    logic [era_pkg::NUM_LINES-1:0] pend;
    logic [era_pkg::NUM_LINES-1:0] next_level;
    logic [era_pkg::NUM_LINES-1:0] next_ref;
    logic [era_pkg::NUM_LINES-1:0] next_pend;
    logic [era_pkg::NUM_LINES-1:0] rd_mask;

    always_comb begin
        // acknowledged ports take the new reference
        rd_mask = port_mask(rd_ack_i);
        next_level = cfg.deb_off ? gpio_i : deb_level;
        // read takes current level as reference
        next_ref = (ref_level & ~rd_mask) | (level & rd_mask);
        next_pend = (level ^ next_ref) & ~cfg.dir;
        if (clr) begin
            next_level = era_pkg::DATA_RESET;
            next_ref = era_pkg::DATA_RESET;
            next_pend = '0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            level <= era_pkg::DATA_RESET;
            ref_level <= era_pkg::DATA_RESET;
            pend <= '0;
        end else begin
            level <= next_level;
            ref_level <= next_ref;
            pend <= next_pend;
        end
    end

    // Registered outputs
    logic next_flag;
    logic [era_pkg::NUM_LINES-1:0] next_gpio;
    logic [era_pkg::NUM_LINES-1:0] next_oe;

    always_comb begin
        // alert follows filtered level by two edges
        // any pending input change raises alert
        next_flag = (|pend) && !clr;
        next_gpio = clr ? era_pkg::DATA_RESET : (cfg.data & cfg.dir);
        next_oe = clr ? era_pkg::DIR_RESET : cfg.dir;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_o <= era_pkg::CFG_RESET;
            gpio_o <= era_pkg::DATA_RESET;
            gpio_oe_o <= era_pkg::DIR_RESET;
            in_level_o <= era_pkg::DATA_RESET;
            input_change_flag_o <= 1'b0;
            alert_o <= 1'b0;
            alert_oe_o <= 1'b0;
        end else begin
            cfg_o <= next_cfg;
            gpio_o <= next_gpio;
            gpio_oe_o <= next_oe;
            in_level_o <= next_level;
            input_change_flag_o <= next_flag;
            alert_o <= 1'b0;
            alert_oe_o <= next_flag;
        end
    end

    // Checks
    // Age of the last full read, saturating so it never wraps
    logic [7:0] clr_age;
    logic [7:0] next_clr_age;

    always_comb begin
        next_clr_age = clr_age;
        if (rd_ack_i == 3'h7 && !clr) begin
            next_clr_age = 8'h01;
        end else if (clr_age != 8'h00 && clr_age != 8'hFF) begin
            next_clr_age = clr_age + 8'h01;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            clr_age <= 8'h00;
        end else begin
            clr_age <= next_clr_age;
        end
    end

    AST_TICK_SPACING: assert property (
        @(posedge clk_i) disable iff (rst_i)
        tick |=> !tick [*8])
        else $error("debounce tick repeated too soon");
    AST_LATENCY: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!tick && !clr) |=> $stable(deb_level))
        else $error("debounced level moved between ticks");
    AST_PIN_RESET: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !reset_n_i |=> (cfg == era_pkg::CFG_RESET && pend == '0)
            ##1 (!alert_oe_o && gpio_oe_o == era_pkg::DIR_RESET))
        else $error("reset pin did not restore defaults");
    AST_NO_CFG_IN_RESET: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!reset_n_i && cfg_wr_i) |=> (cfg_o.dir == era_pkg::DIR_RESET))
        else $error("configuration changed while reset pin low");
    AST_DEFAULT_PULL: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $rose(reset_n_i) |-> (cfg_o.pull_en == era_pkg::PULL_RESET
            && cfg_o.dir == era_pkg::DIR_RESET))
        else $error("lines not inputs with pulldown after reset");
    AST_BYPASS_ALERT: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (cfg.deb_off && reset_n_i && ((gpio_i ^ ref_level) & ~cfg.dir) != '0
            && rd_ack_i == '0 && !cfg_wr_i) ##1 (reset_n_i && rd_ack_i == '0
            && !cfg_wr_i && $stable(gpio_i)) ##1 reset_n_i |=> alert_oe_o)
        else $error("bypassed change did not reach alert in time");
    AST_READ_CLEAR: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (clr_age == 8'h03 && $past(level, 2) == $past(level, 3))
            |-> !alert_oe_o)
        else $error("alert not cleared after full port read");
    AST_CLEAR_BOUND: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (rd_ack_i != '0 && reset_n_i) ##1 $stable(level)
            |=> ((pend & port_mask($past(rd_ack_i, 2))) == '0))
        else $error("read port still pending after its ack");
    AST_REVERT_CLEAR: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (level == ref_level) |=> (pend == '0))
        else $error("reverted input left alert pending");
    AST_OUTPUT_QUIET: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (pend & cfg.dir & $past(cfg.dir)) == '0)
        else $error("output line raised the alert");
    AST_ALERT_FOLLOW: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (reset_n_i && pend != '0) |=> alert_oe_o && input_change_flag_o)
        else $error("pending change not shown on alert");
    AST_FLAG_MATCH: assert property (
        @(posedge clk_i) disable iff (rst_i)
        input_change_flag_o == alert_oe_o)
        else $error("change flag and alert disagree");
    AST_ALERT_LOW: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !alert_o)
        else $error("open-drain alert drove a high level");
    AST_GPIO_DRIVE: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (gpio_o & ~gpio_oe_o) == '0)
        else $error("undriven line shows a drive level");
    AST_BYPASS_LEVEL: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (cfg.deb_off && !clr) |=> (level == $past(gpio_i)))
        else $error("bypass did not pass the pin level");
    AST_DEB_LEVEL: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!cfg.deb_off && !clr) |=> (level == $past(deb_level)))
        else $error("debounce on but level not from stages");
    AST_POR_DEFAULTS: assert property (
        @(posedge clk_i)
        $past(rst_i) |-> (cfg == era_pkg::CFG_RESET && pend == '0
            && !alert_oe_o && tick_cnt == '0))
        else $error("power-on reset left state off its defaults");
    AST_OE_DIR: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !$past(clr) |-> (gpio_oe_o == $past(cfg.dir)))
        else $error("drive enable does not follow direction");
    AST_REF_HOLD: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (rd_ack_i == '0 && !clr) |=> $stable(ref_level))
        else $error("reference moved without a port read");
    AST_IN_LEVEL: assert property (
        @(posedge clk_i) disable iff (rst_i)
        in_level_o == level)
        else $error("filtered level output out of step");
    AST_CNT_RANGE: assert property (
        @(posedge clk_i) disable iff (rst_i)
        tick_cnt <= TW'(DEB_CYCLES - 1))
        else $error("debounce tick counter out of range");
    AST_CLR_STAGES: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !reset_n_i |=> (deb_level == era_pkg::DATA_RESET
            && level == era_pkg::DATA_RESET))
        else $error("reset pin left debounce state set");
    AST_GPIO_IN_RESET: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !reset_n_i |=> ##1 (gpio_o == era_pkg::DATA_RESET))
        else $error("line drive level set while reset pin low");
endmodule

// ===== tb/era_master.sv
// Bus master model driving the reset pin and port read acknowledges
`timescale 1ns/1ps
module era_master (
    input wire logic clk_i,                           // System clock
    output logic reset_n_o,                           // Reset pin drive
    output logic [era_pkg::NUM_PORTS-1:0] rd_ack_o    // Read acknowledge
);
    initial begin
        reset_n_o = 1'b1;
        rd_ack_o = '0;
    end
    task automatic reset_low(input int n);
        @(posedge clk_i);
        #1 reset_n_o = 1'b0;
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic reset_high(input int n);
        reset_n_o = 1'b1;
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic read_port(input int p);
        @(posedge clk_i);
        #1 rd_ack_o[p] = 1'b1;
        @(posedge clk_i);
        #1 rd_ack_o = '0;
    endtask
    // read of all ports in one access
    task automatic read_all();
        @(posedge clk_i);
        #1 rd_ack_o = '1;
        @(posedge clk_i);
        #1 rd_ack_o = '0;
    endtask
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the reset, debounce and alert block
`timescale 1ns/1ps
module tb_top;
    localparam int DEB = 10;
    localparam int REC = 24;
    logic clk_i, rst_i, reset_n, cfg_wr_i, flag, alert_o, alert_oe;
    logic [era_pkg::NUM_LINES-1:0] gpio_i, gpio_o, gpio_oe, lvl, ref_lvl, v;
    logic [era_pkg::NUM_PORTS-1:0] rd_ack;
    logic [31:0] seed;
    era_pkg::era_cfg_t cfg_i, cfg_o, c;
    // Pull-up on the open-drain alert wire
    wire alert_n = alert_oe ? alert_o : 1'b1;
    int n_fail, checks_done, cyc, n, p;

    era_top #(.DEB_CYCLES(DEB)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .reset_n_i(reset_n), .gpio_i(gpio_i), .cfg_wr_i(cfg_wr_i),
        .cfg_i(cfg_i), .rd_ack_i(rd_ack), .cfg_o(cfg_o), .gpio_o(gpio_o),
        .gpio_oe_o(gpio_oe), .in_level_o(lvl),
        .input_change_flag_o(flag), .alert_o(alert_o),
        .alert_oe_o(alert_oe));
    era_master m_u (.clk_i(clk_i), .reset_n_o(reset_n), .rd_ack_o(rd_ack));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic [17:0] pmask(input int q);
        return q == 0 ? 18'h000FF : (q == 1 ? 18'h0FF00 : 18'h30000);
    endfunction
    task automatic tally_and_finish();
        $display("Checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chkv(input string nm, input logic [17:0] e,
                        input logic [17:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chkc(input string nm, input era_pkg::era_cfg_t e,
                        input era_pkg::era_cfg_t g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    task automatic wr_cfg(input era_pkg::era_cfg_t x);
        @(posedge clk_i);
        #1 cfg_i = x;
        cfg_wr_i = 1'b1;
        step(1);
        cfg_wr_i = 1'b0;
        step(1);
    endtask
    task automatic set_chk(input logic [17:0] x);
        gpio_i = x;
        step(4);
        chk1("alert_n", ~|((x ^ ref_lvl) & ~cfg_o.dir), alert_n);
        chk1("input_change_flag_o", |((x ^ ref_lvl) & ~cfg_o.dir), flag);
    endtask

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    initial begin
        rst_i = 1'b1;
        cfg_wr_i = 1'b0;
        cfg_i = era_pkg::CFG_RESET;
        gpio_i = '0;
        n_fail = 0;
        checks_done = 0;
        cyc = 0;
        seed = 32'had50;
        ref_lvl = '0;
        repeat (6) @(posedge clk_i);
        #1 rst_i = 1'b0;
        step(1);
        chkc("cfg_o", era_pkg::CFG_RESET, cfg_o);
        chk1("alert_oe_o", 1'b0, alert_oe);
        c = era_pkg::CFG_RESET;
        c.deb_off = 1'b1;
        wr_cfg(c);
        chk1("deb_off", 1'b1, cfg_o.deb_off);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            v = seed[17:0];
            p = seed[20:19] % 3;
            set_chk(v);
            chkv("in_level_o", v, lvl);
            m_u.read_port(p);
            ref_lvl = (ref_lvl & ~pmask(p)) | (v & pmask(p));
            step(2);
            chk1("alert_n", ~|(v ^ ref_lvl), alert_n);
        end
        m_u.read_all();
        m_u.read_port(0);
        m_u.read_port(1);
        m_u.read_port(2);
        ref_lvl = v;
        set_chk(v ^ 18'h00001);
        set_chk(v);
        c.dir = 18'h000FF;
        c.data = 18'h000AA;
        wr_cfg(c);
        chkv("gpio_oe_o", 18'h000FF, gpio_oe);
        chkv("gpio_o", 18'h000AA, gpio_o);
        set_chk(v ^ 18'h000FF);
        set_chk(v);
        c = era_pkg::CFG_RESET;
        wr_cfg(c);
        step(3 * DEB);
        gpio_i = v ^ 18'h10000;
        step(1);
        gpio_i = v;
        step(3 * DEB);
        chkv("in_level_o", v, lvl);
        gpio_i = v ^ 18'h10000;
        n = 0;
        while (alert_n !== 1'b0 && n < 100) begin
            step(1);
            n++;
        end
        chk1("alert_delay", 1'b1, n >= 4 * DEB / 5 && n <= 2 * DEB + 4);
        chkv("in_level_o", v ^ 18'h10000, lvl);
        m_u.reset_low(REC);
        c.dir = 18'h3FFFF;
        c.data = 18'h3FFFF;
        wr_cfg(c);
        chkc("cfg_o", era_pkg::CFG_RESET, cfg_o);
        chkv("gpio_o", 18'h00000, gpio_o);
        chk1("alert_oe_o", 1'b0, alert_oe);
        m_u.reset_high(REC);
        chkv("gpio_oe_o", 18'h00000, gpio_oe);
        tally_and_finish();
    end
endmodule
